// ===== hw/ssrd_top.sv
// serial slave request decoder: long and short headers, lookup table
//
// Notes on behaviour
// - msb-first: first header bit zero means long request
// - lsb-first: every request is long, short format unavailable
// - op code 00 read, 01 write, 10 table program, 11 reserved
// - long header bits 28:24 hold byte count including latency
// - low 24 long header bits are the start byte address
// - address steps by one per byte, held for the sdio target
// - long header shifts as one 32-bit unit in configured bit order
// - data bytes ascend by address; bit order only reverses within bytes
// - long request spends four header bytes plus latency before data
// - msb-first: first header bit one means short request
// - short requests share op codes; op 10 only legal there
// - short request carries table index into eight programmable entries
// - entry holds address 33:10, length 9:1, auto-increment bit 0
// - auto-increment adds length to entry address after each transfer
// - short op 10 takes next five bytes as entry contents
// - programming bytes arrive least significant byte first
// - upper six bits of fifth programming byte are dropped
// - table entries cannot be read back over the port
// - short requests allow long transfers beyond the long limit
// - short header is eight bits, decoded then looked up
// - one to eight programmable latency bytes before data
// - select release mid-transfer resets decoder for a new header
// - format error on long op 10, index above 7, or zero length
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module ssrd_top #(
  parameter int ENTRIES = ssrd_pkg::TAB_ENTRIES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        sck,
  input  wire logic        serial_select_n,
  input  wire logic        mosi,
  output logic             miso,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  output logic             mem_wr,
  output logic             mem_rd,
  output logic      [23:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic             format_error
);

  // ****************************************
  // declarations
  // ****************************************
  logic [2:0]  sck_q;
  logic [1:0]  ss_q;
  logic [1:0]  mosi_q;
  logic        rise;
  logic        fall;
  logic        sel;
  logic        bit_in;
  logic [15:0] ctrl;
  logic        lsb_first;
  logic        status_err;
  ssrd_pkg::ssrd_state_t state;
  logic [31:0] hdr;
  logic [31:0] hdr_nx;
  logic [5:0]  hcnt;
  logic [2:0]  bitc;
  logic [7:0]  byte_sh;
  logic [7:0]  byte_nx;
  logic        byte_done;
  logic        is_write;
  logic        is_short;
  logic [2:0]  idx;
  logic [23:0] cur_addr;
  logic [23:0] addr_nx;
  logic        hold;
  logic [9:0]  remain;
  logic [3:0]  latn;
  logic [3:0]  latc;
  logic [39:0] tab_sh;
  logic [2:0]  tabc;
  logic        tab_load;
  logic        tab_bump;
  logic        rd_pend;
  logic [7:0]  tx_byte;
  logic [23:0] tab_addr [ENTRIES];
  logic [8:0]  tab_len  [ENTRIES];
  logic        tab_ai   [ENTRIES];
  logic        dec_short;
  logic        dec_now;
  logic [1:0]  dec_op;
  logic [3:0]  dec_id;
  logic [3:0]  dec_lat;
  logic [4:0]  long_len;
  logic [9:0]  dec_len;
  logic        dec_err;

  // ****************************************
  // pin synchronisers and clock edge finding
  // ****************************************
  // two flops per pin; sck gets a third stage for edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_q  <= 3'h0;
      ss_q   <= 2'h3;
      mosi_q <= 2'h0;
    end else if (clk_en) begin
      sck_q  <= {sck_q[1:0], sck};
      ss_q   <= {ss_q[0], serial_select_n};
      mosi_q <= {mosi_q[0], mosi};
    end
  end

  // data sampled on rising sck, driven out on falling sck
  assign rise   = sck_q[1] & ~sck_q[2];
  assign fall   = ~sck_q[1] & sck_q[2];
  assign sel    = ~ss_q[1];
  assign bit_in = mosi_q[1];

  // ****************************************
  // register port
  // ****************************************
  assign lsb_first = ctrl[ssrd_pkg::CTRL_LSB];

  // control word written by software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= ssrd_pkg::CTRL_RESET;
    end else if (clk_en && reg_write && reg_addr == ssrd_pkg::REG_CTRL) begin
      ctrl <= reg_wdata[15:0];
    end
  end

  // sticky error, write one to clear, a new error wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_err <= 1'b0;
    end else if (clk_en) begin
      if (format_error) begin
        status_err <= 1'b1;
      end else if (reg_write && reg_addr == ssrd_pkg::REG_STATUS
                   && reg_wdata[ssrd_pkg::ST_ERR]) begin
        status_err <= 1'b0;
      end
    end
  end

  // read data the cycle after the strobe; table has no read path
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      reg_rdata <= 32'h0;
      if (reg_read) begin
        unique case (reg_addr)
          ssrd_pkg::REG_CTRL:   reg_rdata <= {16'h0, ctrl};
          ssrd_pkg::REG_STATUS: reg_rdata <= {27'h0, state,
                                              state != ssrd_pkg::S_HDR,
                                              status_err};
          default:              reg_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // shifting and header decode
  // ****************************************
  // header shifts whole in the configured order, bytes likewise
  always_comb begin
    hdr_nx  = lsb_first ? {bit_in, hdr[31:1]} : {hdr[30:0], bit_in};
    byte_nx = lsb_first ? {bit_in, byte_sh[7:1]} : {byte_sh[6:0], bit_in};
  end

  assign byte_done = rise && bitc == 3'h7;
  assign hold      = ctrl[ssrd_pkg::CTRL_SDIO_EN]
                     && cur_addr[23:16] == ctrl[ssrd_pkg::CTRL_SDIO_PG+:8];
  assign addr_nx   = hold ? cur_addr : cur_addr + 24'h1;

  // decode of a complete short or long header
  always_comb begin
    dec_short = !lsb_first && hcnt == ssrd_pkg::SHORT_END && hdr_nx[7];
    dec_now   = dec_short || hcnt == ssrd_pkg::LONG_END;
    dec_op    = dec_short ? hdr_nx[6:5] : hdr_nx[30:29];
    dec_id    = hdr_nx[3:0];
    dec_lat   = {1'b0, ctrl[((dec_op == ssrd_pkg::OP_WRITE) ? ssrd_pkg::CTRL_WLAT
                             : ssrd_pkg::CTRL_RLAT)+:3]} + 4'h1;
    long_len  = hdr_nx[28:24];
    dec_len   = 10'h0;
    if (dec_short) begin
      dec_len = {1'b0, tab_len[dec_id[2:0]]};
    end else if (long_len > {1'b0, dec_lat}) begin
      dec_len = {5'h0, long_len - {1'b0, dec_lat}};
    end
    if (dec_short) begin
      dec_err = dec_id[3] || (dec_op != ssrd_pkg::OP_TABLE
                && tab_len[dec_id[2:0]] == 9'h0);
    end else begin
      dec_err = dec_op == ssrd_pkg::OP_TABLE || long_len == 5'h0;
    end
  end

  // ****************************************
  // request sequencer
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state        <= ssrd_pkg::S_HDR;
      hdr          <= 32'h0;
      hcnt         <= 6'h0;
      bitc         <= 3'h0;
      byte_sh      <= 8'h0;
      is_write     <= 1'b0;
      is_short     <= 1'b0;
      idx          <= 3'h0;
      cur_addr     <= 24'h0;
      remain       <= 10'h0;
      latn         <= 4'h1;
      latc         <= 4'h0;
      tab_sh       <= 40'h0;
      tabc         <= 3'h0;
      mem_wr       <= 1'b0;
      mem_rd       <= 1'b0;
      mem_addr     <= 24'h0;
      mem_wdata    <= 8'h0;
      format_error <= 1'b0;
      tab_load     <= 1'b0;
      tab_bump     <= 1'b0;
    end else if (clk_en) begin
      mem_wr       <= 1'b0;
      mem_rd       <= 1'b0;
      format_error <= 1'b0;
      tab_load     <= 1'b0;
      tab_bump     <= 1'b0;
      if (!sel) begin
        // release aborts whatever is in flight
        state <= ssrd_pkg::S_HDR;
        hcnt  <= 6'h0;
        bitc  <= 3'h0;
      end else if (rise) begin
        bitc    <= bitc + 3'h1;
        byte_sh <= byte_nx;
        unique case (state)
          ssrd_pkg::S_HDR: begin
            hdr  <= hdr_nx;
            hcnt <= hcnt + 6'h1;
            bitc <= 3'h0;
            if (dec_now) begin
              is_short <= dec_short;
              idx      <= dec_id[2:0];
              if (dec_err) begin
                state        <= ssrd_pkg::S_SINK;
                format_error <= 1'b1;
              end else if (dec_op == ssrd_pkg::OP_RSVD) begin
                state <= ssrd_pkg::S_SINK;
              end else if (dec_op == ssrd_pkg::OP_TABLE) begin
                state <= ssrd_pkg::S_TAB;
                tabc  <= 3'h0;
              end else begin
                state    <= ssrd_pkg::S_LAT;
                is_write <= dec_op == ssrd_pkg::OP_WRITE;
                cur_addr <= dec_short ? tab_addr[dec_id[2:0]]
                                      : hdr_nx[23:0];
                remain   <= dec_len;
                latn     <= dec_lat;
                latc     <= 4'h0;
              end
            end
            if (!dec_now && !lsb_first && hcnt == ssrd_pkg::SHORT_END) begin
              is_short <= 1'b0;
            end
          end
          ssrd_pkg::S_LAT: begin
            if (byte_done) begin
              latc <= latc + 4'h1;
              if (latc == latn - 4'h1) begin
                if (remain == 10'h0) begin
                  state <= ssrd_pkg::S_SINK;
                end else begin
                  state    <= ssrd_pkg::S_DATA;
                  mem_rd   <= !is_write;
                  mem_addr <= cur_addr;
                end
              end
            end
          end
          ssrd_pkg::S_DATA: begin
            if (byte_done) begin
              cur_addr <= addr_nx;
              remain   <= remain - 10'h1;
              if (is_write) begin
                mem_wr    <= 1'b1;
                mem_wdata <= byte_nx;
                mem_addr  <= cur_addr;
              end
              if (remain == 10'h1) begin
                state    <= ssrd_pkg::S_SINK;
                tab_bump <= is_short && tab_ai[idx];
              end else if (!is_write) begin
                mem_rd   <= 1'b1;
                mem_addr <= addr_nx;
              end
            end
          end
          ssrd_pkg::S_TAB: begin
            if (byte_done) begin
              tab_sh <= {byte_nx, tab_sh[39:8]};
              tabc   <= tabc + 3'h1;
              if (tabc == ssrd_pkg::TAB_LAST) begin
                state    <= ssrd_pkg::S_SINK;
                tab_load <= 1'b1;
              end
            end
          end
          ssrd_pkg::S_SINK: begin
            bitc <= 3'h0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // lookup table, one entry per generate step
  // ****************************************
  for (genvar g = 0; g < ENTRIES; g++) begin : g_entry
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        tab_addr[g] <= 24'h0;
        tab_len[g]  <= 9'h0;
        tab_ai[g]   <= 1'b0;
      end else if (clk_en) begin
        if (tab_load && idx == 3'(g)) begin
          tab_addr[g] <= tab_sh[33:ssrd_pkg::TAB_ADDR_LO];
          tab_len[g]  <= tab_sh[9:ssrd_pkg::TAB_LEN_LO];
          tab_ai[g]   <= tab_sh[0];
        end else if (tab_bump && idx == 3'(g)) begin
          tab_addr[g] <= tab_addr[g] + {15'h0, tab_len[g]};
        end
      end
    end
  end

  // ****************************************
  // read data serialiser
  // ****************************************
  // memory answers one cycle after mem_rd; bits leave on falling sck
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pend <= 1'b0;
      tx_byte <= 8'h0;
      miso    <= 1'b0;
    end else if (clk_en) begin
      rd_pend <= mem_rd;
      if (rd_pend) begin
        tx_byte <= mem_rdata;
      end
      if (!sel || state != ssrd_pkg::S_DATA || is_write) begin
        miso <= 1'b0;
      end else if (fall) begin
        miso <= lsb_first ? tx_byte[bitc] : tx_byte[3'h7 - bitc];
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_desel;
    @(posedge clk) disable iff (!reset_n || !clk_en)
    !sel |=> state == ssrd_pkg::S_HDR && hcnt == 6'h0;
  endproperty
  a_desel: assert property (p_desel) else $error("no reset on release");

  property p_lsb_long;
    @(posedge clk) disable iff (!reset_n || !clk_en)
    (state == ssrd_pkg::S_HDR && sel && rise && lsb_first
     && hcnt == ssrd_pkg::SHORT_END) |=> state == ssrd_pkg::S_HDR;
  endproperty
  a_lsb_long: assert property (p_lsb_long) else $error("short in lsb mode");

  property p_short;
    @(posedge clk) disable iff (!reset_n || !clk_en)
    (state == ssrd_pkg::S_HDR && sel && rise && dec_short)
    |=> state != ssrd_pkg::S_HDR && is_short;
  endproperty
  a_short: assert property (p_short) else $error("short header missed");

  property p_long;
    @(posedge clk) disable iff (!reset_n || !clk_en)
    (state == ssrd_pkg::S_HDR && sel && rise && !lsb_first
     && hcnt == ssrd_pkg::SHORT_END && !hdr_nx[7])
    |=> state == ssrd_pkg::S_HDR && hcnt == 6'd8;
  endproperty
  a_long: assert property (p_long) else $error("long header cut short");

  property p_op10;
    @(posedge clk) disable iff (!reset_n || !clk_en)
    (state == ssrd_pkg::S_HDR && sel && rise && hcnt == ssrd_pkg::LONG_END
     && hdr_nx[30:29] == ssrd_pkg::OP_TABLE)
    |=> format_error ##1 status_err;
  endproperty
  a_op10: assert property (p_op10) else $error("long op 10 accepted");

  property p_inc;
    @(posedge clk) disable iff (!reset_n || !clk_en)
    (sel && state == ssrd_pkg::S_DATA && byte_done && !hold)
    |=> cur_addr == $past(cur_addr) + 24'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("address did not step");

  property p_tab;
    @(posedge clk) disable iff (!reset_n || !clk_en)
    tab_load |=> tab_addr[idx] == $past(tab_sh[33:10])
                 && tab_len[idx] == $past(tab_sh[9:1]);
  endproperty
  a_tab: assert property (p_tab) else $error("entry load wrong");

  property p_bump;
    @(posedge clk) disable iff (!reset_n || !clk_en)
    tab_bump |=> tab_addr[idx] == $past(tab_addr[idx])
                 + {15'h0, $past(tab_len[idx])};
  endproperty
  a_bump: assert property (p_bump) else $error("auto-increment wrong");

  property p_sink;
    @(posedge clk) disable iff (!reset_n || !clk_en)
    (state == ssrd_pkg::S_SINK && $past(state) == ssrd_pkg::S_SINK)
    |-> !mem_wr && !mem_rd && !miso;
  endproperty
  a_sink: assert property (p_sink) else $error("access after end");

  c_short_rd: cover property (@(posedge clk) is_short && mem_rd);
  c_long_wr:  cover property (@(posedge clk) !is_short && mem_wr);
  c_tab:      cover property (@(posedge clk) tab_load);
  c_err:      cover property (@(posedge clk) format_error);

endmodule : ssrd_top

// ===== hw/ssrd_pkg.sv
// constants and types shared by the serial request decoder
package ssrd_pkg;

  // ****************************************
  // register map (word index on reg_addr)
  // ****************************************
  localparam logic [1:0]  REG_CTRL     = 2'h0;
  localparam logic [1:0]  REG_STATUS   = 2'h1;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam int          CTRL_LSB     = 0;
  localparam int          CTRL_WLAT    = 1;
  localparam int          CTRL_RLAT    = 4;
  localparam int          CTRL_SDIO_EN = 7;
  localparam int          CTRL_SDIO_PG = 8;
  localparam int          ST_ERR       = 0;
  localparam int          ST_BUSY      = 1;

  // ****************************************
  // request format
  // ****************************************
  localparam logic [1:0] OP_READ   = 2'h0;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_TABLE  = 2'h2;
  localparam logic [1:0] OP_RSVD   = 2'h3;
  localparam logic [5:0] SHORT_END = 6'd7;
  localparam logic [5:0] LONG_END  = 6'd31;
  localparam logic [2:0] TAB_LAST  = 3'd4;
  localparam int         TAB_ENTRIES = 8;
  localparam int         ADDR_W    = 24;
  localparam int         TLEN_W    = 9;
  localparam int         TAB_LEN_LO  = 1;
  localparam int         TAB_ADDR_LO = 10;

  // ****************************************
  // decoder states
  // ****************************************
  typedef enum logic [2:0] {
    S_HDR  = 3'b000,
    S_TAB  = 3'b001,
    S_LAT  = 3'b010,
    S_DATA = 3'b011,
    S_SINK = 3'b100
  } ssrd_state_t;

endpackage : ssrd_pkg

// ===== sim/ssrd_host_model.sv
// host serial master model: frames requests and shifts bytes on the link
`timescale 1ns/10ps
module ssrd_host_model (
  output logic      sck,
  output logic      serial_select_n,
  output logic      mosi,
  input  wire logic miso
);
  localparam time HALF = 80ns; // half of the 160 ns link period

  // idle: clock low and still, device not selected
  initial begin
    sck = 1'b0;
    serial_select_n = 1'b1;
    mosi = 1'b1;
  end

  // select the device; the clock stays low until the first bit
  task automatic frame_start();
    #7ns;
    serial_select_n = 1'b0;
  endtask : frame_start

  // one byte msb first: data moves while the clock is low, both sides sample on the rise
  task automatic shift8(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #HALF;
      sck = 1'b1;
      #1ns;
      rx[i] = miso;
      #(HALF - 1ns);
      sck = 1'b0;
    end
  endtask : shift8

  // deselect; the released data line shows the inverse of its last value
  task automatic frame_end();
    #HALF;
    serial_select_n = 1'b1;
    mosi = ~mosi;
    #200ns; // several system clocks between frames
  endtask : frame_end
endmodule : ssrd_host_model

// ===== sim/tb.sv
// self-checking bench for the serial request decoder
`timescale 1ns/10ps
module tb;
  // ****************************************
  // signals and bench state
  // ****************************************
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        sck, serial_select_n, mosi, miso;
  logic [1:0]  reg_addr = 2'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        clk_en = 1'b1;
  logic [31:0] reg_rdata;
  logic        mem_wr, mem_rd, format_error;
  logic [23:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata = 8'h00;
  logic [31:0] wq[$];
  logic [7:0]  rxq[$];
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          rd_cnt = 0;
  int          fe_cnt = 0;
  int          cyc = 0;
  int          n0;

  ssrd_top dut (
    .clk             (clk),
    .reset_n         (reset_n),
    .clk_en          (clk_en),
    .sck             (sck),
    .serial_select_n (serial_select_n),
    .mosi            (mosi),
    .miso            (miso),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_write       (reg_write),
    .reg_read        (reg_read),
    .reg_rdata       (reg_rdata),
    .mem_wr          (mem_wr),
    .mem_rd          (mem_rd),
    .mem_addr        (mem_addr),
    .mem_wdata       (mem_wdata),
    .mem_rdata       (mem_rdata),
    .format_error    (format_error)
  );

  ssrd_host_model host (
    .sck             (sck),
    .serial_select_n (serial_select_n),
    .mosi            (mosi),
    .miso            (miso)
  );

  always #10ns clk = ~clk;

  // memory side: log writes, answer reads the cycle after the strobe, count errors, watchdog
  always @(posedge clk) begin
    if (mem_wr) wq.push_back({mem_addr, mem_wdata});
    if (mem_rd) mem_rdata <= mem_addr[7:0] ^ 8'h5a;
    if (mem_rd) rd_cnt++;
    if (format_error) fe_cnt++;
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  // read strobe for one cycle, data taken in the cycle after it
  task automatic rchk(input logic [1:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1ns;
    check(reg_rdata, exp);
  endtask : rchk

  function automatic logic [31:0] lh(logic [1:0] op, logic [4:0] n, logic [23:0] a);
    return {1'b0, op, n, a};
  endfunction : lh

  function automatic logic [31:0] sh(logic [1:0] op, logic [3:0] idx);
    return {24'h0, 1'b1, op, 1'b0, idx};
  endfunction : sh

  // header of hb bytes, lat dummy bytes, nd data bytes 30h+i; received bytes go to rxq
  task automatic frame(input logic [31:0] h, input int hb, input logic lsb, input int lat,
                       input int nd);
    logic [31:0] hh;
    logic [7:0]  r;
    logic [7:0]  t;
    hh = lsb ? {<<{h}} : h;
    rxq.delete();
    host.frame_start();
    for (int b = hb - 1; b >= 0; b--) host.shift8(hh[b*8+:8], r);
    for (int i = 0; i < lat; i++) host.shift8(8'h00, r);
    for (int i = 0; i < nd; i++) begin
      t = 8'h30 + 8'(i);
      if (lsb) t = {<<{t}};
      host.shift8(t, r);
      rxq.push_back(lsb ? {<<{r}} : r);
    end
    host.frame_end();
  endtask : frame

  // program one table entry: five bytes, least significant first
  task automatic prog(input logic [3:0] idx, input logic [39:0] e);
    logic [7:0] r;
    host.frame_start();
    host.shift8(sh(ssrd_pkg::OP_TABLE, idx), r);
    for (int b = 0; b < 5; b++) host.shift8(e[b*8+:8], r);
    host.frame_end();
  endtask : prog

  task automatic ewr(input logic [23:0] a, input int n, input int step);
    logic [31:0] e;
    for (int i = 0; i < n; i++) begin
      e = (wq.size() != 0) ? wq.pop_front() : 32'hxxxxxxxx;
      check(e, {a + 24'(step * i), 8'h30 + 8'(i)});
    end
    check(32'(wq.size()), 32'h0);
  endtask : ewr

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(ssrd_pkg::REG_CTRL, 32'h0);
    rchk(ssrd_pkg::REG_STATUS, 32'h0);
    reg_wr(2'h3, 32'hffff);
    rchk(2'h3, 32'h0);
    rchk(ssrd_pkg::REG_CTRL, 32'h0);
    // clock enable low: a register write must not land
    clk_en <= 1'b0;
    reg_wr(ssrd_pkg::REG_CTRL, 32'h1);
    clk_en <= 1'b1;
    rchk(ssrd_pkg::REG_CTRL, 32'h0);
    // long write msb first, one latency byte
    frame(lh(ssrd_pkg::OP_WRITE, 5'd3, 24'h123456), 4, 1'b0, 1, 2);
    ewr(24'h123456, 2, 1);
    // lsb first: first header bit is one, still a long request
    reg_wr(ssrd_pkg::REG_CTRL, 32'h1);
    frame(lh(ssrd_pkg::OP_WRITE, 5'd4, 24'h0000a1), 4, 1'b1, 1, 3);
    ewr(24'h0000a1, 3, 1);
    // lsb-first read with two read latency bytes
    reg_wr(ssrd_pkg::REG_CTRL, 32'h11);
    frame(lh(ssrd_pkg::OP_READ, 5'd4, 24'h000250), 4, 1'b1, 2, 2);
    check({rxq[0], rxq[1]}, {8'h50 ^ 8'h5a, 8'h51 ^ 8'h5a});
    // held address on the sdio page, two latency bytes
    reg_wr(ssrd_pkg::REG_CTRL, 32'h1282);
    frame(lh(ssrd_pkg::OP_WRITE, 5'd5, 24'h120010), 4, 1'b0, 2, 3);
    ewr(24'h120010, 3, 0);
    reg_wr(ssrd_pkg::REG_CTRL, 32'h0);
    // long read
    n0 = rd_cnt;
    frame(lh(ssrd_pkg::OP_READ, 5'd3, 24'h000240), 4, 1'b0, 1, 2);
    check(rxq[0], 8'h40 ^ 8'h5a);
    check(rxq[1], 8'h41 ^ 8'h5a);
    check(32'(rd_cnt - n0), 32'h2);
    // select dropped mid-header, then a clean write
    frame(32'h2fff0000, 2, 1'b0, 0, 0);
    frame(lh(ssrd_pkg::OP_WRITE, 5'd2, 24'h0000c0), 4, 1'b0, 1, 1);
    ewr(24'h0000c0, 1, 1);
    // reserved op: no access, idle data
    n0 = rd_cnt;
    frame(lh(ssrd_pkg::OP_RSVD, 5'd3, 24'h000300), 4, 1'b0, 1, 2);
    check(rxq[0] | rxq[1], 8'h00);
    check(32'(rd_cnt - n0), 32'h0);
    ewr(24'h0, 0, 1);
    // short requests through the table, auto-increment on, then off
    prog(4'd2, {6'h3f, 24'hc01000, 9'd2, 1'b1});
    frame(sh(ssrd_pkg::OP_WRITE, 4'd2), 1, 1'b0, 1, 2);
    ewr(24'hc01000, 2, 1);
    frame(sh(ssrd_pkg::OP_WRITE, 4'd2), 1, 1'b0, 1, 2);
    ewr(24'hc01002, 2, 1);
    frame(sh(ssrd_pkg::OP_READ, 4'd2), 1, 1'b0, 1, 2);
    check({rxq[0], rxq[1]}, {8'h04 ^ 8'h5a, 8'h05 ^ 8'h5a});
    prog(4'd2, {6'h00, 24'hc01000, 9'd2, 1'b0});
    frame(sh(ssrd_pkg::OP_WRITE, 4'd2), 1, 1'b0, 1, 2);
    ewr(24'hc01000, 2, 1);
    // short transfer beyond the long limit
    prog(4'd3, {6'h00, 24'h004000, 9'd40, 1'b0});
    frame(sh(ssrd_pkg::OP_WRITE, 4'd3), 1, 1'b0, 1, 40);
    ewr(24'h004000, 40, 1);
    // format errors: long table op, index above seven, zero length
    n0 = fe_cnt;
    frame(lh(ssrd_pkg::OP_TABLE, 5'd3, 24'h0), 4, 1'b0, 1, 0);
    frame(sh(ssrd_pkg::OP_WRITE, 4'd8), 1, 1'b0, 1, 0);
    prog(4'd5, 40'h0);
    frame(sh(ssrd_pkg::OP_READ, 4'd5), 1, 1'b0, 1, 0);
    frame(lh(ssrd_pkg::OP_WRITE, 5'd0, 24'h0), 4, 1'b0, 1, 0);
    check(32'(fe_cnt - n0), 32'h4);
    ewr(24'h0, 0, 1);
    rchk(ssrd_pkg::REG_STATUS, 32'h1);
    reg_wr(ssrd_pkg::REG_STATUS, 32'h1);
    rchk(ssrd_pkg::REG_STATUS, 32'h0);
    give_verdict();
  end
endmodule : tb
